// [design/clock_select_map.svh]
// constants of the system clock select and prescaler block
// Contract
// - rc source nominal 8.0MHz, select code 0010
// - reset loads factory calibration into trim
// - watchdog and reset timeout use watchdog oscillator
// - rc start-up: 6 clocks wake, 14 plus delay
// - 128kHz source selected by code 0011
// - 128kHz start-up: 6 wake, 14 plus 4/64ms
// - external clock selected by code 0000
// - external start-up: 6 wake, 14 plus delay
// - timer oscillator only with rc, four times slower
// - async enable lets timer pin take clock
// - clock output fuse drives clock pin, also reset; in reset the code enables the pin but holds it low
// - clock output carries the divided clock; the code toggles it per divided tick, giving half that rate
// - prescaler divides all system clocks together
// - no glitches, no faster intermediate frequency
// - new rate active within T1+T2 to T1+2*T2
// - prescaler is hidden ripple counter on master clock
// - division code accepted only within four cycles
// - enable set only alone, clears after four
// - codes 0000..1000 divide 1..256, others reserved
// - reset code 0011 with divide fuse, else 0000
`ifndef CLOCK_SELECT_MAP_SVH
`define CLOCK_SELECT_MAP_SVH
`define SRC_EXTERNAL      4'h0
`define SRC_RC_8MHZ       4'h2
`define SRC_LOWPOWER_128K 4'h3
`define SUT_SHORT         2'h0
`define SUT_MEDIUM        2'h1
`define SUT_LONG          2'h2
`define WAKE_CLOCKS       16'h0006
`define RESET_CLOCKS      16'h000E
`define DELAY_4MS_US      4000
`define DELAY_4P1MS_US    4100
`define DELAY_64MS_US     64000
`define DELAY_65MS_US     65000
`define CLK_MHZ           10
`define CHANGE_WINDOW     3'h4
`define CHANGE_BIT        7
`define DIV_MAX_CODE      4'h8
`define DIV_RESET_FUSED   4'h3
`define DIV_RESET_PLAIN   4'h0
`define WORD_CHANGE_ONLY  8'h80
`endif

// [design/clock_select_pkg.sv]
// types of the system clock select and prescaler block
package clock_select_pkg;
    typedef struct packed {
        logic [3:0] source_select;
        logic [1:0] startup_time;
        logic       clock_output;
        logic       initial_divide;
    } fuse_s;
    typedef enum logic [1:0] {
        SEL_EXTERNAL,
        SEL_RC,
        SEL_LOWPOWER,
        SEL_INVALID
    } source_e;
    typedef enum {
        ST_RESET_HOLD,
        ST_RESET_DELAY,
        ST_RUN,
        ST_WAKE_DELAY
    } phase_e;
endpackage

// [design/system_clock_select_prescaler.sv]
// clock source selection, start-up delay and glitch-free prescaler
`timescale 1ns/10ps
`default_nettype none
`include "clock_select_map.svh"
module system_clock_select_prescaler #(
    parameter int unsigned CLK_MHZ = `CLK_MHZ,
    parameter int unsigned DELAY_4MS   = `DELAY_4MS_US * CLK_MHZ,
    parameter int unsigned DELAY_4P1MS = `DELAY_4P1MS_US * CLK_MHZ,
    parameter int unsigned DELAY_64MS  = `DELAY_64MS_US * CLK_MHZ,
    parameter int unsigned DELAY_65MS  = `DELAY_65MS_US * CLK_MHZ
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire clock_select_pkg::fuse_s fuses,
    input  wire logic [7:0]             factory_calibration,
    input  wire logic                   watchdog_osc_tick,
    input  wire logic                   trim_write,
    input  wire logic [7:0]             trim_write_data,
    input  wire logic                   prescale_write,
    input  wire logic [7:0]             prescale_write_data,
    input  wire logic                   async_ext_clock_enable,
    input  wire logic                   timer_osc_pin_one,
    input  wire logic                   wake_request,
    output logic [7:0]                  rc_trim_value,
    output logic [1:0]                  source_active,
    output logic                        source_invalid,
    output logic                        timer_osc_allowed,
    output logic                        timer_clock_in,
    output logic [7:0]                  prescale_control_register,
    output logic                        system_clock_enable,
    output logic                        clock_output_pin,
    output logic                        clock_output_oe,
    output logic                        core_running
);
    // ------------------------------------------------------------
    // fuse capture and calibration
    // ------------------------------------------------------------
    clock_select_pkg::fuse_s   fuse_r, fuse_nxt;
    clock_select_pkg::source_e src_r, src_nxt;
    logic [7:0] trim_r, trim_nxt;
    logic       in_reset_r;
    logic       fuse_load;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_reset_r <= 1'b1;
        end else begin
            in_reset_r <= 1'b0;
        end
    end
    // capture at the first edge after release, inputs static
    assign fuse_load = in_reset_r;
    always_comb begin
        fuse_nxt = fuse_r;
        src_nxt  = src_r;
        trim_nxt = trim_r;
        if (fuse_load) begin
            fuse_nxt = fuses;
            trim_nxt = factory_calibration;
            unique case (fuses.source_select)
                `SRC_RC_8MHZ:       src_nxt = clock_select_pkg::SEL_RC;
                `SRC_LOWPOWER_128K: src_nxt = clock_select_pkg::SEL_LOWPOWER;
                `SRC_EXTERNAL:      src_nxt = clock_select_pkg::SEL_EXTERNAL;
                default:            src_nxt = clock_select_pkg::SEL_INVALID;
            endcase
        end else if (trim_write) begin
            trim_nxt = trim_write_data;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fuse_r <= '0;
            src_r  <= clock_select_pkg::SEL_RC;
            trim_r <= 8'h00;
        end else begin
            fuse_r <= fuse_nxt;
            src_r  <= src_nxt;
            trim_r <= trim_nxt;
        end
    end
    // ------------------------------------------------------------
    // start-up delays
    // ------------------------------------------------------------
    // reset timeout is counted on watchdog oscillator ticks, not clk
    clock_select_pkg::phase_e phase_r, phase_nxt;
    logic [31:0] count_r, count_nxt;
    logic [31:0] extra_delay;
    always_comb begin
        extra_delay = 32'h0000_0000;
        unique case (fuse_r.startup_time)
            `SUT_SHORT:  extra_delay = 32'h0000_0000;
            `SUT_MEDIUM: extra_delay = (src_r == clock_select_pkg::SEL_LOWPOWER)
                ? DELAY_4MS : DELAY_4P1MS;
            `SUT_LONG:   extra_delay = (src_r == clock_select_pkg::SEL_LOWPOWER)
                ? DELAY_64MS : DELAY_65MS;
            default:     extra_delay = 32'h0000_0000;
        endcase
    end
    always_comb begin
        phase_nxt = phase_r;
        count_nxt = count_r;
        unique case (phase_r)
            clock_select_pkg::ST_RESET_HOLD: begin
                if (!fuse_load) begin
                    phase_nxt = clock_select_pkg::ST_RESET_DELAY;
                    count_nxt = 32'(`RESET_CLOCKS) + extra_delay;
                end
            end
            clock_select_pkg::ST_RESET_DELAY: begin
                if (count_r == 32'h0000_0000) begin
                    phase_nxt = clock_select_pkg::ST_RUN;
                end else if (watchdog_osc_tick) begin
                    count_nxt = count_r - 32'h0000_0001;
                end
            end
            clock_select_pkg::ST_RUN: begin
                if (wake_request) begin
                    phase_nxt = clock_select_pkg::ST_WAKE_DELAY;
                    // the request edge is the first of the wake clocks
                    count_nxt = 32'(`WAKE_CLOCKS) - 32'h0000_0001;
                end
            end
            clock_select_pkg::ST_WAKE_DELAY: begin
                if (count_r == 32'h0000_0000) begin
                    phase_nxt = clock_select_pkg::ST_RUN;
                end else begin
                    count_nxt = count_r - 32'h0000_0001;
                end
            end
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= clock_select_pkg::ST_RESET_HOLD;
            count_r <= 32'h0000_0000;
        end else begin
            phase_r <= phase_nxt;
            count_r <= count_nxt;
        end
    end
    // ------------------------------------------------------------
    // prescale control register
    // ------------------------------------------------------------
    logic       change_en_r, change_en_nxt;
    logic [2:0] window_r, window_nxt;
    logic [3:0] code_r, code_nxt;
    always_comb begin
        change_en_nxt = change_en_r;
        window_nxt    = window_r;
        code_nxt      = code_r;
        if (fuse_load) begin
            code_nxt = fuses.initial_divide ? `DIV_RESET_FUSED
                                            : `DIV_RESET_PLAIN;
        end
        if (change_en_r) begin
            window_nxt = window_r - 3'h1;
            if (window_r == 3'h1) begin
                change_en_nxt = 1'b0;
            end
        end
        if (prescale_write) begin
            if (prescale_write_data == `WORD_CHANGE_ONLY) begin
                if (!change_en_r) begin
                    change_en_nxt = 1'b1;
                    window_nxt    = `CHANGE_WINDOW;
                end
            end else if (!prescale_write_data[`CHANGE_BIT] && change_en_r) begin
                code_nxt      = prescale_write_data[3:0];
                change_en_nxt = 1'b0;
                window_nxt    = 3'h0;
            end
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            change_en_r <= 1'b0;
            window_r    <= 3'h0;
            code_r      <= `DIV_RESET_PLAIN;
        end else begin
            change_en_r <= change_en_nxt;
            window_r    <= window_nxt;
            code_r      <= code_nxt;
        end
    end
    // ------------------------------------------------------------
    // glitch-free prescaler
    // ------------------------------------------------------------
    // the active code changes only on a tick boundary of the old rate,
    // so the interval in between is one old period then the new one
    logic [7:0] ripple_r, ripple_nxt;
    logic [3:0] active_r, active_nxt;
    logic       tick_r, tick_nxt;
    logic [7:0] div_mask;
    logic [3:0] code_eff;
    // reserved codes keep the last legal division
    assign code_eff = (code_r > `DIV_MAX_CODE) ? active_r : code_r;
    always_comb begin
        div_mask = 8'hff >> (4'h8 - active_r);
        if (active_r == 4'h0) begin
            div_mask = 8'h00;
        end
    end
    always_comb begin
        ripple_nxt = ripple_r + 8'h01;
        active_nxt = active_r;
        tick_nxt   = 1'b0;
        if ((ripple_r & div_mask) == div_mask) begin
            tick_nxt   = 1'b1;
            ripple_nxt = 8'h00;
            active_nxt = code_eff;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ripple_r <= 8'h00;
            active_r <= `DIV_RESET_PLAIN;
            tick_r   <= 1'b0;
        end else begin
            ripple_r <= ripple_nxt;
            active_r <= active_nxt;
            tick_r   <= tick_nxt;
        end
    end
    // ------------------------------------------------------------
    // timer oscillator pin
    // ------------------------------------------------------------
    // the pin pair is shared with the crystal, so only the rc source
    // leaves it free; allowed follows the source on the same edge
    logic tmr_ok_r, tmr_ok_nxt;
    logic tmr_clk_r, tmr_clk_nxt;
    always_comb begin
        tmr_ok_nxt  = (src_nxt == clock_select_pkg::SEL_RC);
        tmr_clk_nxt = tmr_ok_r && async_ext_clock_enable
                    && timer_osc_pin_one;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tmr_ok_r  <= 1'b0;
            tmr_clk_r <= 1'b0;
        end else begin
            tmr_ok_r  <= tmr_ok_nxt;
            tmr_clk_r <= tmr_clk_nxt;
        end
    end
    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // registered from the next-state values so that they change on
    // the same edge as the state they describe
    logic inv_r, inv_nxt;
    logic run_r, run_nxt;
    always_comb begin
        inv_nxt = (src_nxt == clock_select_pkg::SEL_INVALID);
        run_nxt = (phase_nxt == clock_select_pkg::ST_RUN);
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inv_r <= 1'b0;
            run_r <= 1'b0;
        end else begin
            inv_r <= inv_nxt;
            run_r <= run_nxt;
        end
    end
    // ------------------------------------------------------------
    // clock output pin
    // ------------------------------------------------------------
    logic clk_out_r, clk_out_nxt;
    logic oe_r, oe_nxt;
    always_comb begin
        // toggles per divided tick: a half-rate image of the system clock
        clk_out_nxt = tick_nxt ? !clk_out_r : clk_out_r;
        oe_nxt      = fuse_load ? fuses.clock_output
                                : fuse_r.clock_output;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_out_r <= 1'b0;
        end else begin
            clk_out_r <= clk_out_nxt;
        end
    end
    // no reset here: the enable must follow the fuse while reset is
    // held, and fuse_load stays high for all of that time
    always_ff @(posedge clk) begin
        oe_r <= oe_nxt;
    end
    // limitation: while reset is held the pin is enabled but stays low
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rc_trim_value             = trim_r;
    assign source_active             = src_r;
    assign source_invalid            = inv_r;
    assign timer_osc_allowed         = tmr_ok_r;
    assign timer_clock_in            = tmr_clk_r;
    assign prescale_control_register = {change_en_r, 3'h0, code_r};
    assign system_clock_enable       = tick_r;
    assign clock_output_pin          = clk_out_r;
    assign clock_output_oe           = oe_r;
    assign core_running              = run_r;
endmodule // system_clock_select_prescaler
`default_nettype wire

// [tb/clock_select_monitor.sv]
// assertions on the ports of the clock select and prescaler block
`timescale 1ns/10ps
`default_nettype none
module clock_select_monitor (
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire clock_select_pkg::fuse_s fuses,
    input wire logic [7:0]              factory_calibration,
    input wire logic                    prescale_write,
    input wire logic [7:0]              prescale_write_data,
    input wire logic                    async_ext_clock_enable,
    input wire logic                    timer_osc_pin_one,
    input wire logic [7:0]              rc_trim_value,
    input wire logic [1:0]              source_active,
    input wire logic                    timer_osc_allowed,
    input wire logic                    timer_clock_in,
    input wire logic [7:0]              prescale_control_register,
    input wire logic                    clock_output_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic       en = prescale_control_register[7];
    wire logic [7:0] wd = prescale_write_data;
    property p_trim_load;
        $rose(reset_n) |=> rc_trim_value == $past(factory_calibration);
    endproperty
    a_trim_load: assert property (p_trim_load)
        else $error("trim not loaded from calibration");
    property p_change_set;
        prescale_write && wd == 8'h80 && !en |=> en;
    endproperty
    a_change_set: assert property (p_change_set)
        else $error("change enable not set");
    property p_change_clear;
        $rose(en) |-> ##[1:4] !en;
    endproperty
    a_change_clear: assert property (p_change_clear)
        else $error("change enable held too long");
    property p_code_refused;
        prescale_write && !en && !wd[7]
            |=> $stable(prescale_control_register[3:0]);
    endproperty
    a_code_refused: assert property (p_code_refused)
        else $error("code taken without enable");
    property p_code_accept;
        prescale_write && en && wd[7:4] == 4'h0 && wd[3:0] <= 4'h8
            |=> prescale_control_register == $past(wd);
    endproperty
    a_code_accept: assert property (p_code_accept)
        else $error("code not taken in window");
    property p_oe_fuse;
        1'b1 |=> clock_output_oe == $past(fuses.clock_output);
    endproperty
    a_oe_fuse: assert property (p_oe_fuse)
        else $error("clock output enable differs from fuse");
    property p_timer_allowed;
        timer_osc_allowed |-> source_active == 2'h1;
    endproperty
    a_timer_allowed: assert property (p_timer_allowed)
        else $error("timer oscillator allowed off rc");
    property p_timer_clock;
        1'b1 |=> timer_clock_in == ($past(timer_osc_pin_one)
            && $past(timer_osc_allowed) && $past(async_ext_clock_enable));
    endproperty
    a_timer_clock: assert property (p_timer_clock)
        else $error("timer clock path wrong");
    c_accept: cover property (prescale_write && en && !wd[7]);
    c_timeout: cover property ($fell(en) && !$past(prescale_write));
    c_timer: cover property ($rose(timer_clock_in));
endmodule // clock_select_monitor
bind system_clock_select_prescaler clock_select_monitor clock_select_monitor_i (
    .clk(clk), .reset_n(reset_n), .fuses(fuses),
    .factory_calibration(factory_calibration),
    .prescale_write(prescale_write), .prescale_write_data(prescale_write_data),
    .async_ext_clock_enable(async_ext_clock_enable),
    .timer_osc_pin_one(timer_osc_pin_one), .rc_trim_value(rc_trim_value),
    .source_active(source_active), .timer_osc_allowed(timer_osc_allowed),
    .timer_clock_in(timer_clock_in),
    .prescale_control_register(prescale_control_register),
    .clock_output_oe(clock_output_oe));
`default_nettype wire

// [tb/cpu_model.sv]
// software side model: prescaler writes and watchdog oscillator ticks
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
    input  wire logic  clk,
    output logic       prescale_write,
    output logic [7:0] prescale_write_data,
    output logic       watchdog_osc_tick
);
    logic [1:0] tick_cnt = 2'h0;
    initial begin
        prescale_write = 1'b0;
        prescale_write_data = 8'h5a;
        watchdog_osc_tick = 1'b0;
    end
    // slow oscillator: one tick every fourth master cycle
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        watchdog_osc_tick <= #1 (tick_cnt == 2'h3);
    end
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        #1;
        prescale_write = 1'b1;
        prescale_write_data = d;
        @(posedge clk);
        #1;
        prescale_write = 1'b0;
        // released data must not look like a valid word
        prescale_write_data = ~d;
    endtask
    // no other access is slipped between the two writes
    task automatic set_div(input logic [3:0] code, input int gap);
        wr(8'h80);
        repeat (gap) @(posedge clk);
        wr({4'h0, code});
    endtask
endmodule // cpu_model
`default_nettype wire

// [tb/system_clock_select_prescaler_tb.sv]
// self-checking bench for the clock select and prescaler block
`timescale 1ns/10ps
`default_nettype none
module system_clock_select_prescaler_tb;
    logic clk = 1'b0, reset_n = 1'b0, tw = 1'b0, wake = 1'b0;
    logic aen = 1'b0, tpin = 1'b0, pw, tick, inv, alw, tclk, sce, cko, oe;
    logic run, q;
    logic [7:0] pwd, trim, pcr;
    logic [7:0] cal = 8'ha5, twd = 8'h3c;
    logic [1:0] src;
    clock_select_pkg::fuse_s fuses = '0;
    int mismatches = 0, n_tests = 0, p, n;
    always #50 clk = ~clk;
    cpu_model cpu_model_i (.clk(clk), .prescale_write(pw),
        .prescale_write_data(pwd), .watchdog_osc_tick(tick));
    system_clock_select_prescaler #(.DELAY_4MS(20), .DELAY_4P1MS(20),
        .DELAY_64MS(20), .DELAY_65MS(20)) system_clock_select_prescaler_i (
        .clk(clk), .reset_n(reset_n), .fuses(fuses),
        .factory_calibration(cal), .watchdog_osc_tick(tick),
        .trim_write(tw), .trim_write_data(twd), .prescale_write(pw),
        .prescale_write_data(pwd), .async_ext_clock_enable(aen),
        .timer_osc_pin_one(tpin), .wake_request(wake), .rc_trim_value(trim),
        .source_active(src), .source_invalid(inv), .timer_osc_allowed(alw),
        .timer_clock_in(tclk), .prescale_control_register(pcr),
        .system_clock_enable(sce), .clock_output_pin(cko),
        .clock_output_oe(oe), .core_running(run));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic restart(input logic [3:0] s, input logic [1:0] t,
                           input logic d, input logic o);
        reset_n = 1'b0;
        fuses = '{s, t, o, d};
        cyc(20);
        reset_n = 1'b1;
        cyc(2);
    endtask
    // cycles from one enable pulse to the next
    task automatic period(output int k);
        k = 0;
        while (sce !== 1'b1 && k < 600) begin cyc(1); k++; end
        k = 0;
        do begin cyc(1); k++; end while (sce !== 1'b1 && k < 600);
    endtask
    task automatic finish_test;
        if (mismatches == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    logic [3:0] sel [4] = '{4'h0, 4'h2, 4'h3, 4'h5};
    logic [1:0] act [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    initial begin
        cyc(1);
        for (int i = 0; i < 4; i++) begin
            cal = {4'ha, 4'(i)};
            restart(sel[i], i[1:0], i[0], i[1]);
            chk(src, act[i]);
            chk(inv, act[i] == 2'h3);
            chk(alw, act[i] == 2'h1);
            chk(pcr, i[0] ? 8'h03 : 8'h00);
            chk(trim, cal);
            chk(oe, i[1]);
        end
        restart(4'h2, 2'h1, 1'b0, 1'b1);
        cyc(110);
        chk(run, 1'b0);
        n = 0;
        while (run !== 1'b1 && n < 200) begin cyc(1); n++; end
        chk(run, 1'b1);
        tw = 1'b1;
        cyc(1);
        tw = 1'b0;
        cyc(1);
        chk(trim, twd);
        aen = 1'b1;
        tpin = 1'b1;
        cyc(3);
        chk(tclk, 1'b1);
        tpin = 1'b0;
        cyc(3);
        chk(tclk, 1'b0);
        wake = 1'b1;
        cyc(1);
        wake = 1'b0;
        n = 0;
        while (run !== 1'b1 && n < 50) begin cyc(1); n++; end
        chk(n, 6);
        for (int c = 0; c <= 8; c++) begin
            cpu_model_i.set_div(c[3:0], c[0] ? 2 : 0);
            chk(pcr, c);
            period(p);
            period(p);
            q = cko;
            period(p);
            chk(p, 1 << c);
            chk(cko, !q);
        end
        cpu_model_i.set_div(4'h5, 5);
        chk(pcr, 8'h08);
        cpu_model_i.wr(8'h04);
        chk(pcr, 8'h08);
        cpu_model_i.wr(8'h81);
        cpu_model_i.wr(8'h02);
        chk(pcr, 8'h08);
        cpu_model_i.wr(8'h80);
        cpu_model_i.wr(8'h80);
        cpu_model_i.wr(8'h80);
        cpu_model_i.wr(8'h03);
        chk(pcr, 8'h08);
        cpu_model_i.set_div(4'h9, 0);
        chk(pcr, 8'h09);
        period(p);
        period(p);
        period(p);
        chk(p, 256);
        finish_test();
    end
    initial begin
        #8_000_000;
        mismatches++;
        finish_test();
    end
endmodule // system_clock_select_prescaler_tb
`default_nettype wire
